/* core/mifd_consts.svh */
// Constants for the micro-instruction field decoder: bus offsets, reset values,
// field masks and opcode values. Assumes inclusion by bare name.
`ifndef MIFD_CONSTS_SVH
`define MIFD_CONSTS_SVH
// ==========================================================================
// Register offsets (byte addresses on the 32-bit bus)
`define MIFD_OFF_CTRL 8'h00
`define MIFD_OFF_STATUS 8'h04
`define MIFD_OFF_MASK 8'h08
`define MIFD_OFF_STATE 8'h0C
`define MIFD_CTRL_RESET 8'h01
`define MIFD_MASK_RESET 4'h0
// ==========================================================================
// Status bit positions
`define MIFD_EV_SHUTDOWN 0
`define MIFD_EV_PARITY 1
`define MIFD_EV_ALARM 2
`define MIFD_EV_TEST 3
// ==========================================================================
// Micro-op classes, upper four instruction bits; load class upper three bits
`define MIFD_OP_DECODE 4'h0
`define MIFD_OP_BRANCH 4'h1
`define MIFD_OP_TEST 4'h2
`define MIFD_OP_COMMAND 4'h3
`define MIFD_OP_LOAD 3'h2
// ==========================================================================
// E field masks and values, and register codes
`define MIFD_E_CARRY_MASK 4'h3
`define MIFD_E_CARRY_IN 4'h2
`define MIFD_E_CARRY_OUT 4'h1
`define MIFD_E_CARRY_BOTH 4'h3
`define MIFD_E_FLAGS 4'h4
`define MIFD_E_NO_ACC 4'h8
`define MIFD_E_SHIFT_MASK 4'hC
`define MIFD_E_SHL 4'h8
`define MIFD_E_SHR 4'h4
`define MIFD_E_XSH 4'hC
`define MIFD_E_MEM_READ 4'h8
`define MIFD_E_COPY_FLAGS 4'h4
`define MIFD_E_CLEAR 4'h2
`define MIFD_E_PHASE 4'h1
`define MIFD_E_ADD_DEFAULT 4'h7
`define MIFD_E_LOAD_DEFAULT 4'h3
`define MIFD_REG_IO 4'hD
`define MIFD_REG_AR 4'h8
`define MIFD_REG_LOOP_COUNTER 4'hC
`define MIFD_REG_IRDEST 4'hB
`define MIFD_REG_LAST_BANKED 4'h2
// ==========================================================================
// Command field masks and values, and the mask of assigned test bits
`define MIFD_C_ARITH_MASK 12'hC00
`define MIFD_C_DIV 12'h800
`define MIFD_C_MPY 12'h400
`define MIFD_C_RPT 12'hC00
`define MIFD_C_MEM_MASK 12'h300
`define MIFD_C_MRD 12'h100
`define MIFD_C_MWR 12'h200
`define MIFD_C_PWR 12'h300
`define MIFD_C_BANK_MASK 12'h0C0
`define MIFD_C_BANK_CLR 12'h040
`define MIFD_C_BANK_SET 12'h080
`define MIFD_C_BANK_TGL 12'h0C0
`define MIFD_C_UT_MASK 12'h030
`define MIFD_C_UT_CLR 12'h010
`define MIFD_C_UT_SET 12'h020
`define MIFD_C_UT_TGL 12'h030
`define MIFD_C_WA_MASK 12'h00C
`define MIFD_C_WA_CLR 12'h004
`define MIFD_C_WA_SET 12'h008
`define MIFD_C_PAR_CLR 12'h002
`define MIFD_C_POWER 12'h001
`define MIFD_T_ASSIGNED 12'h7F8
`endif

/* core/mifd_pkg.sv */
// Types for the micro-instruction field decoder.
// Assumes the constants header is compiled alongside.
package mifd_pkg;
    typedef logic [15:0] mifd_word_t;
    typedef logic [3:0] mifd_efield_t;
    typedef logic [11:0] mifd_cmd_t;
endpackage

/* core/mifd_decoder.sv */
// Micro-instruction field decoder with a Wishbone register slave.
// Assumes a micro-instruction word on the same clock and asynchronous condition pins.
`timescale 1ns/10ps
`include "mifd_consts.svh"

// How it works
// - Add-class low E bits choose carry in, carry out, both or none.
// - Add-class E bit 0100 clear suppresses flags; bit 1000 drops the accumulator.
// - Load high E bits choose shift left, right, cross or plain transfer.
// - Load low E bits choose carries with the add-class patterns.
// - Decode E bits: memory read, flag copy, clear, phase change.
// - Branch condition zero tests loop counter not equal to one.
// - Branch condition bits select less, greater, overflow, carry in any mix.
// - Command bits C00 pick divide, multiply or repeat.
// - Command bits 300 start memory read, write or privileged write.
// - Command bits drive bank and spare flip-flops: clear, set, toggle.
// - Command bits request power down, clear parity latch, clear/set wait alarm.
// - Test field bits select the sampled conditions.
// - Test bits 800, 004, 002, 001 sample nothing.
// - Register codes map destination and source, with bank steering codes 0-2.
// - Immediate add and load forms take the default E field; other forms decode their own E bits.
module mifd_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq_o,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic flag_lt_i,
    input wire logic flag_gt_i,
    input wire logic flag_ovf_i,
    input wire logic flag_carry_i,
    input wire logic loop_count_not_one_i,
    input wire logic io_interrupt_pin_i,
    input wire logic auto_restart_pin_i,
    input wire logic console_interrupt_pin_i,
    input wire logic single_step_pin_i,
    input wire logic primary_power_fail_pin_i,
    input wire logic fast_io_pin_i,
    input wire logic memory_parity_error_pin_i,
    output logic carry_in_o,
    output logic carry_out_o,
    output logic flags_suppress_o,
    output logic skip_accumulator_operand_o,
    output logic shift_left_o,
    output logic shift_right_o,
    output logic cross_shift_o,
    output logic io_address_qualifier_o,
    output logic io_word_ready_o,
    output logic io_command_o,
    output logic io_acknowledge_o,
    output logic io_data_request_o,
    output logic io_status_request_o,
    output logic memory_read_o,
    output logic copy_flags_o,
    output logic zero_out_o,
    output logic phase_advance_o,
    output logic branch_taken_o,
    output logic [7:0] branch_target_o,
    output logic divide_o,
    output logic multiply_step_o,
    output logic repeat_op_o,
    output logic mem_cycle_read_o,
    output logic memory_write_o,
    output logic protected_write_o,
    output logic bank_o,
    output logic spare_flag_o,
    output logic wait_alarm_o,
    output logic memory_parity_error_o,
    output logic shutdown_request_o,
    output logic parity_error_clear_o,
    output logic test_hit_o,
    output logic [3:0] dest_code_o,
    output logic [3:0] source_code_o,
    output logic dest_scratch_o,
    output logic source_scratch_o,
    output logic source_null_o,
    output logic source_ir_dest_field_o,
    output logic dest_io_o,
    output logic source_io_o
);
    // ======================================================================
    // Condition pin synchronisers
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_ok;
    assign pin_raw = {io_interrupt_pin_i, auto_restart_pin_i, console_interrupt_pin_i,
                      single_step_pin_i, primary_power_fail_pin_i, fast_io_pin_i,
                      memory_parity_error_pin_i};
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        logic s1;
        logic s2;
        logic s3;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
                pin_ok[g] <= 1'b0;
            end else begin
                s1 <= pin_raw[g];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    pin_ok[g] <= s3;
                end
            end
        end
    end

    // ======================================================================
    // Field decode
    logic en;
    logic take;
    logic [3:0] op;
    mifd_pkg::mifd_efield_t e;
    mifd_pkg::mifd_cmd_t cf;
    logic is_add;
    logic is_load;
    logic is_dec;
    logic is_cmd;
    logic is_tst;
    logic is_br;
    logic [3:0] cc;
    logic br_hit;
    logic [11:0] tvec;
    assign take = en && instr_valid_i;
    assign op = instr_i[15:12];
    assign cf = instr_i[11:0];
    assign cc = instr_i[11:8];
    assign is_add = take && (op[3] || op[3:1] == 3'h3);
    assign is_load = take && (op[3:1] == `MIFD_OP_LOAD);
    assign is_dec = take && (op == `MIFD_OP_DECODE);
    assign is_cmd = take && (op == `MIFD_OP_COMMAND);
    assign is_tst = take && (op == `MIFD_OP_TEST);
    assign is_br = take && (op == `MIFD_OP_BRANCH);
    // Immediate forms carry a constant instead of an E field; default E applies.
    always_comb begin
        e = instr_i[3:0];
        if (is_add && op[0]) begin
            e = `MIFD_E_ADD_DEFAULT;
        end else if (is_load && op[0]) begin
            e = `MIFD_E_LOAD_DEFAULT;
        end
    end
    // Condition zero means the loop counter test; other bits combine as any-of.
    assign br_hit = (cc == 4'h0) ? loop_count_not_one_i
                  : |(cc & {flag_carry_i, flag_ovf_i, flag_gt_i, flag_lt_i});
    // Unassigned test bits carry constant zero.
    assign tvec = {1'b0, pin_ok[6], pin_ok[5], pin_ok[4], pin_ok[3], spare_flag_o,
                   memory_parity_error_o, pin_ok[2], pin_ok[1], 3'h0};

    logic ld_shift;
    logic ld_io_d;
    logic ld_io_s;
    assign ld_shift = is_load || is_add;
    assign ld_io_d = is_load && instr_i[11:8] == `MIFD_REG_IO;
    assign ld_io_s = is_load && !op[0] && instr_i[7:4] == `MIFD_REG_IO;

    // ======================================================================
    // Datapath control strobes, one cycle after the word is presented
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_in_o <= 1'b0;
            carry_out_o <= 1'b0;
            flags_suppress_o <= 1'b0;
            skip_accumulator_operand_o <= 1'b0;
            shift_left_o <= 1'b0;
            shift_right_o <= 1'b0;
            cross_shift_o <= 1'b0;
        end else begin
            carry_in_o <= ld_shift && (e & `MIFD_E_CARRY_MASK) inside
                {`MIFD_E_CARRY_IN, `MIFD_E_CARRY_BOTH};
            carry_out_o <= ld_shift && (e & `MIFD_E_CARRY_MASK) inside
                {`MIFD_E_CARRY_OUT, `MIFD_E_CARRY_BOTH};
            flags_suppress_o <= is_add && (e & `MIFD_E_FLAGS) == 4'h0;
            skip_accumulator_operand_o <= is_add && (e & `MIFD_E_NO_ACC) == `MIFD_E_NO_ACC;
            shift_left_o <= is_load && (e & `MIFD_E_SHIFT_MASK) == `MIFD_E_SHL;
            shift_right_o <= is_load && (e & `MIFD_E_SHIFT_MASK) == `MIFD_E_SHR;
            cross_shift_o <= is_load && (e & `MIFD_E_SHIFT_MASK) == `MIFD_E_XSH;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_address_qualifier_o <= 1'b0;
            io_word_ready_o <= 1'b0;
            io_command_o <= 1'b0;
            io_acknowledge_o <= 1'b0;
            io_data_request_o <= 1'b0;
            io_status_request_o <= 1'b0;
            memory_read_o <= 1'b0;
            copy_flags_o <= 1'b0;
            zero_out_o <= 1'b0;
            phase_advance_o <= 1'b0;
        end else begin
            io_address_qualifier_o <= ld_io_d && e[1:0] == 2'h1;
            io_word_ready_o <= ld_io_d && e[1:0] == 2'h2;
            io_command_o <= ld_io_d && e[1:0] == 2'h3;
            io_acknowledge_o <= ld_io_s && e[1:0] == 2'h1;
            io_data_request_o <= ld_io_s && e[1:0] == 2'h2;
            io_status_request_o <= ld_io_s && e[1:0] == 2'h3;
            memory_read_o <= is_dec && |(e & `MIFD_E_MEM_READ);
            copy_flags_o <= is_dec && |(e & `MIFD_E_COPY_FLAGS);
            zero_out_o <= is_dec && |(e & `MIFD_E_CLEAR);
            phase_advance_o <= is_dec && |(e & `MIFD_E_PHASE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            branch_taken_o <= 1'b0;
            branch_target_o <= 8'h00;
            test_hit_o <= 1'b0;
            divide_o <= 1'b0;
            multiply_step_o <= 1'b0;
            repeat_op_o <= 1'b0;
            mem_cycle_read_o <= 1'b0;
            memory_write_o <= 1'b0;
            protected_write_o <= 1'b0;
            shutdown_request_o <= 1'b0;
            parity_error_clear_o <= 1'b0;
        end else begin
            branch_taken_o <= is_br && br_hit;
            branch_target_o <= is_br ? instr_i[7:0] : 8'h00;
            test_hit_o <= is_tst && |(cf & tvec);
            divide_o <= is_cmd && (cf & `MIFD_C_ARITH_MASK) == `MIFD_C_DIV;
            multiply_step_o <= is_cmd && (cf & `MIFD_C_ARITH_MASK) == `MIFD_C_MPY;
            repeat_op_o <= is_cmd && (cf & `MIFD_C_ARITH_MASK) == `MIFD_C_RPT;
            mem_cycle_read_o <= is_cmd && (cf & `MIFD_C_MEM_MASK) == `MIFD_C_MRD;
            memory_write_o <= is_cmd && (cf & `MIFD_C_MEM_MASK) == `MIFD_C_MWR;
            protected_write_o <= is_cmd && (cf & `MIFD_C_MEM_MASK) == `MIFD_C_PWR;
            shutdown_request_o <= is_cmd && |(cf & `MIFD_C_POWER);
            parity_error_clear_o <= is_cmd && |(cf & `MIFD_C_PAR_CLR);
        end
    end

    // ======================================================================
    // Command-driven flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_o <= 1'b0;
            spare_flag_o <= 1'b0;
            wait_alarm_o <= 1'b0;
        end else if (is_cmd) begin
            unique case (cf & `MIFD_C_BANK_MASK)
                `MIFD_C_BANK_CLR: bank_o <= 1'b0;
                `MIFD_C_BANK_SET: bank_o <= 1'b1;
                `MIFD_C_BANK_TGL: bank_o <= !bank_o;
                default: bank_o <= bank_o;
            endcase
            unique case (cf & `MIFD_C_UT_MASK)
                `MIFD_C_UT_CLR: spare_flag_o <= 1'b0;
                `MIFD_C_UT_SET: spare_flag_o <= 1'b1;
                `MIFD_C_UT_TGL: spare_flag_o <= !spare_flag_o;
                default: spare_flag_o <= spare_flag_o;
            endcase
            if ((cf & `MIFD_C_WA_MASK) == `MIFD_C_WA_CLR) begin
                wait_alarm_o <= 1'b0;
            end else if ((cf & `MIFD_C_WA_MASK) == `MIFD_C_WA_SET) begin
                wait_alarm_o <= 1'b1;
            end
        end
    end

    // A parity error arriving with the clear command stays latched.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            memory_parity_error_o <= 1'b0;
        end else if (pin_ok[0]) begin
            memory_parity_error_o <= 1'b1;
        end else if (is_cmd && |(cf & `MIFD_C_PAR_CLR)) begin
            memory_parity_error_o <= 1'b0;
        end
    end

    // ======================================================================
    // Register code steering
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dest_code_o <= 4'h0;
            source_code_o <= 4'h0;
            dest_scratch_o <= 1'b0;
            source_scratch_o <= 1'b0;
            source_null_o <= 1'b0;
            source_ir_dest_field_o <= 1'b0;
            dest_io_o <= 1'b0;
            source_io_o <= 1'b0;
        end else begin
            dest_code_o <= instr_i[11:8];
            source_code_o <= instr_i[7:4];
            dest_scratch_o <= bank_o && instr_i[11:8] <= `MIFD_REG_LAST_BANKED;
            source_scratch_o <= bank_o && instr_i[7:4] <= `MIFD_REG_LAST_BANKED;
            source_null_o <= instr_i[7:4] inside {`MIFD_REG_AR, `MIFD_REG_LOOP_COUNTER};
            source_ir_dest_field_o <= instr_i[7:4] == `MIFD_REG_IRDEST;
            dest_io_o <= instr_i[11:8] == `MIFD_REG_IO;
            source_io_o <= instr_i[7:4] == `MIFD_REG_IO;
        end
    end

    // ======================================================================
    // Wishbone slave, interrupt status and mask
    logic [7:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] events;
    logic acc;
    logic rd_status;
    logic wa_prev;
    assign en = ctrl[0];
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_status = acc && !wb_we_i && wb_adr_i == `MIFD_OFF_STATUS;
    assign events = {test_hit_o, wait_alarm_o && !wa_prev,
                     pin_ok[0], shutdown_request_o};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl <= `MIFD_CTRL_RESET;
            mask <= `MIFD_MASK_RESET;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= 32'h0000_0000;
            if (acc && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == `MIFD_OFF_CTRL) begin
                    ctrl <= wb_dat_i[7:0];
                end
                if (wb_adr_i == `MIFD_OFF_MASK) begin
                    mask <= wb_dat_i[3:0];
                end
            end
            if (acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    `MIFD_OFF_CTRL: wb_dat_o <= {24'h00_0000, ctrl};
                    `MIFD_OFF_STATUS: wb_dat_o <= {28'h000_0000, status};
                    `MIFD_OFF_MASK: wb_dat_o <= {28'h000_0000, mask};
                    `MIFD_OFF_STATE: wb_dat_o <= {28'h000_0000, memory_parity_error_o,
                                                  wait_alarm_o, spare_flag_o, bank_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // A new event in the read cycle survives the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= 4'h0;
            irq_o <= 1'b0;
            wa_prev <= 1'b0;
        end else begin
            wa_prev <= wait_alarm_o;
            status <= (rd_status ? 4'h0 : status) | events;
            irq_o <= |(((rd_status ? 4'h0 : status) | events) & mask);
        end
    end

    // ======================================================================
    // Checks
    sequence s_add;
        is_add;
    endsequence
    sequence s_load;
        is_load;
    endsequence
    sequence s_cmd;
        is_cmd;
    endsequence

    chk_add_carry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_add |=> carry_in_o == $past(e[1]) && carry_out_o == $past(e[0]))
        else $error("add carry decode wrong");
    chk_add_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        s_add |=> flags_suppress_o == !$past(e[2]) && skip_accumulator_operand_o == $past(e[3]))
        else $error("add flag or accumulator decode wrong");
    chk_load_shift: assert property (@(posedge clk_i) disable iff (rst_i)
        s_load ##0 (e[3:2] == 2'h3) |=> cross_shift_o && !shift_left_o && !shift_right_o)
        else $error("cross shift decode wrong");
    chk_load_carry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_load |=> carry_in_o == $past(e[1]))
        else $error("load carry decode wrong");
    chk_decode_read: assert property (@(posedge clk_i) disable iff (rst_i)
        is_dec |=> memory_read_o == $past(e[3]) && phase_advance_o == $past(e[0]))
        else $error("decode field wrong");
    chk_branch_loop: assert property (@(posedge clk_i) disable iff (rst_i)
        is_br && cc == 4'h0 |=> branch_taken_o == $past(loop_count_not_one_i))
        else $error("loop branch wrong");
    chk_cmd_arith: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cmd ##0 (cf[11:10] == 2'h3) |=> repeat_op_o && !divide_o && !multiply_step_o)
        else $error("repeat decode wrong");
    chk_bank_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cmd ##0 (cf[7:6] == 2'h3) |=> bank_o != $past(bank_o))
        else $error("bank toggle wrong");
    chk_test_unassigned: assert property (@(posedge clk_i) disable iff (rst_i)
        is_tst && (cf & `MIFD_T_ASSIGNED) == 12'h000 |=> !test_hit_o)
        else $error("unassigned test bit hit");
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
endmodule

/* verification/mifd_store.sv */
// Behavioural model of the microprogram store that feeds the decoder.
// Assumes a fetch request one cycle ahead of the word that it returns.
`timescale 1ns/10ps
module mifd_store (
    input wire logic clk_i,
    input wire logic fetch_i,
    input wire logic plain_i,
    input wire logic [15:0] word_i,
    output logic [15:0] word_o,
    output logic valid_o
);
    logic [15:0] nx;
    initial word_o = 16'hA5A5;
    initial valid_o = 1'b0;
    // Outside a fetch the word lines toggle, so no stale word looks valid.
    always @(posedge clk_i) begin
        nx = fetch_i ? word_i : ~word_o;
        if (fetch_i && plain_i && word_i[15:12] >= 4'h6) begin
            nx[3:0] = 4'h7;
        end
        if (fetch_i && plain_i && word_i[15:12] == 4'h4) begin
            nx[3:0] = 4'h3;
        end
        if (fetch_i && plain_i && word_i[15:12] == 4'h0) begin
            nx[3:0] = 4'h0;
        end
        valid_o <= fetch_i;
        word_o <= nx;
    end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the field decoder, fed through the store model.
// Assumes the core files and the store model are compiled before it.
`timescale 1ns/10ps
`include "mifd_consts.svh"
module tb_top;
    logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, fetch = 0, plain = 0;
    logic [7:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'hF;
    logic [15:0] word = 0, instr_i, w;
    logic flag_lt_i = 0, flag_gt_i = 0, flag_ovf_i = 0, flag_carry_i = 0;
    logic loop_count_not_one_i = 0, io_interrupt_pin_i = 0, auto_restart_pin_i = 0;
    logic console_interrupt_pin_i = 0, single_step_pin_i = 0, primary_power_fail_pin_i = 0;
    logic fast_io_pin_i = 0, memory_parity_error_pin_i = 0, instr_valid_i, wb_ack_o, irq_o;
    logic carry_in_o, carry_out_o, flags_suppress_o, skip_accumulator_operand_o, shift_left_o;
    logic shift_right_o, cross_shift_o, io_address_qualifier_o, io_word_ready_o, io_command_o;
    logic io_acknowledge_o, io_data_request_o, io_status_request_o, memory_read_o, copy_flags_o;
    logic zero_out_o, phase_advance_o, branch_taken_o, divide_o, multiply_step_o, repeat_op_o;
    logic mem_cycle_read_o, memory_write_o, protected_write_o, bank_o, spare_flag_o;
    logic wait_alarm_o, memory_parity_error_o, shutdown_request_o, parity_error_clear_o;
    logic test_hit_o, dest_scratch_o, source_scratch_o, source_null_o, source_ir_dest_field_o;
    logic dest_io_o, source_io_o;
    logic [7:0] branch_target_o;
    logic [3:0] dest_code_o, source_code_o;
    logic bk = 0, sp = 0, wa = 0, pl = 0, en = 1;
    int seed = 32'h432C5431, bad_count = 0, total_checks = 0, cyc = 0;
    logic [15:0] tab [$] = {16'h3C00, 16'h3800, 16'h3400, 16'h3300, 16'h3200, 16'h31C0,
        16'h3080, 16'h3040, 16'h30F0, 16'h3010, 16'h3020, 16'h3006, 16'h300A, 16'h3004,
        16'h3008, 16'h300C, 16'h200F, 16'h27F8, 16'h1000, 16'h1F00, 16'h1300, 16'h0000,
        16'h000F, 16'h4D01, 16'h4D02, 16'h4D03, 16'h41D1, 16'h41D2, 16'h41D3, 16'h400C,
        16'h4008, 16'h4004, 16'hC12F, 16'hC120};
    wire [26:0] got = {carry_in_o, carry_out_o, flags_suppress_o, skip_accumulator_operand_o,
        shift_left_o, shift_right_o, cross_shift_o, io_address_qualifier_o, io_word_ready_o,
        io_command_o, io_acknowledge_o, io_data_request_o, io_status_request_o, memory_read_o,
        copy_flags_o, zero_out_o, phase_advance_o, branch_taken_o, divide_o, multiply_step_o,
        repeat_op_o, mem_cycle_read_o, memory_write_o, protected_write_o, shutdown_request_o,
        parity_error_clear_o, test_hit_o};

    mifd_decoder mifd_decoder_inst (.*);
    mifd_store mifd_store_inst (.clk_i(clk_i), .fetch_i(fetch), .plain_i(plain), .word_i(word),
        .word_o(instr_i), .valid_o(instr_valid_i));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ==================================================================
    // Expected values
    function automatic logic [26:0] ex(input logic [15:0] v);
        logic [3:0] e;
        logic [3:0] o;
        ex = 0;
        o = v[15:12];
        e = !o[0] ? v[3:0] : o >= 4'h6 ? `MIFD_E_ADD_DEFAULT : `MIFD_E_LOAD_DEFAULT;
        if (!en) return ex;
        if (o >= 4'h6) ex[26:23] = {e[1], e[0], !e[2], e[3]};
        if (o[3:1] == 3'h2) begin
            ex[26:25] = e[1:0];
            ex[22:20] = {e[3:2] == 2'b10, e[3:2] == 2'b01, &e[3:2]};
            if (v[11:8] == 4'hD) ex[19:17] = {e[1:0] == 2'b01, e[1:0] == 2'b10, &e[1:0]};
            if (v[7:4] == 4'hD && !o[0])
                ex[16:14] = {e[1:0] == 2'b01, e[1:0] == 2'b10, &e[1:0]};
        end
        if (o == 4'h0) ex[13:10] = e;
        if (o == 4'h1) ex[9] = v[11:8] != 0 ? |(v[11:8] & {flag_carry_i, flag_ovf_i, flag_gt_i,
            flag_lt_i}) : loop_count_not_one_i;
        if (o == 4'h3) ex[8:1] = {v[11:10] == 2'b10, v[11:10] == 2'b01, &v[11:10],
            v[9:8] == 2'b01, v[9:8] == 2'b10, &v[9:8], v[0], v[1]};
        if (o == 4'h2) ex[0] = |(v[10:3] & {io_interrupt_pin_i, auto_restart_pin_i,
            console_interrupt_pin_i, single_step_pin_i, sp, pl, primary_power_fail_pin_i,
            fast_io_pin_i});
    endfunction

    function automatic logic ff(input logic [1:0] c, input logic q);
        return c == 2'b11 ? !q : c == 2'b10 ? 1'b1 : c == 2'b01 ? 1'b0 : q;
    endfunction

    // ==================================================================
    // Drivers and checks
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask

    task automatic issue(input logic [15:0] v, input logic p);
        logic [26:0] x;
        logic [15:0] wd;
        {io_interrupt_pin_i, auto_restart_pin_i, console_interrupt_pin_i, single_step_pin_i,
            primary_power_fail_pin_i, fast_io_pin_i, memory_parity_error_pin_i} <=
            7'($random(seed));
        repeat (5) @(posedge clk_i);
        pl = pl | memory_parity_error_pin_i;
        {flag_lt_i, flag_gt_i, flag_ovf_i, flag_carry_i, loop_count_not_one_i} <=
            5'($random(seed));
        {fetch, plain, word} <= {1'b1, p, v};
        @(posedge clk_i);
        fetch <= 1'b0;
        #1;
        wd = instr_i;
        x = ex(wd);
        @(posedge clk_i);
        #1;
        ck(got, x);
        ck(branch_target_o, en && wd[15:12] == 4'h1 ? wd[7:0] : 8'h00);
        if (en && wd[15:12] == 4'h3) begin
            bk = ff(wd[7:6], bk);
            sp = ff(wd[5:4], sp);
            wa = wd[3:2] == 2'b10 ? 1'b1 : wd[3:2] == 2'b01 ? 1'b0 : wa;
            pl = (pl & !wd[1]) | memory_parity_error_pin_i;
        end
        ck({bank_o, spare_flag_o, wait_alarm_o, memory_parity_error_o}, {bk, sp, wa, pl});
        ck({dest_code_o, source_code_o, source_null_o, source_ir_dest_field_o, dest_io_o,
            source_io_o}, {wd[11:4], wd[7:4] == 8 || wd[7:4] == 12, wd[7:4] == 11,
            wd[11:8] == 13, wd[7:4] == 13});
        if (wd[15:12] != 4'h3) ck({dest_scratch_o, source_scratch_o}, {bk & (wd[11:8] <= 2),
            bk & (wd[7:4] <= 2)});
        @(posedge clk_i);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, `MIFD_OFF_CTRL, 0);
        ck(rd, 32'h1);
        wb(0, `MIFD_OFF_MASK, 0);
        ck(rd, 32'h0);
        wb(0, 8'h40, 0);
        ck(rd, 32'h0);
        wb(1, `MIFD_OFF_MASK, 32'h1);
        issue(16'h3001, 0);
        repeat (2) @(posedge clk_i);
        #1;
        ck(irq_o, 1);
        @(posedge clk_i);
        wb(0, `MIFD_OFF_STATUS, 0);
        ck(rd[0], 1);
        repeat (2) @(posedge clk_i);
        #1;
        ck(irq_o, 0);
        @(posedge clk_i);
        wb(1, `MIFD_OFF_CTRL, 0);
        en = 0;
        issue(16'hC127, 0);
        wb(1, `MIFD_OFF_CTRL, 32'h1);
        en = 1;
        foreach (tab[i]) issue(tab[i], 0);
        issue(16'hC120, 1);
        issue(16'h4120, 1);
        issue(16'h012F, 1);
        repeat (400) begin
            w = 16'($random(seed));
            if (w[11:4] == 8'hDD) w[4] = 1'b0;
            issue(w, 1'($random(seed)));
        end
        wb(0, `MIFD_OFF_STATE, 0);
        ck(rd, {pl, wa, sp, bk});
        end_sim();
    end
endmodule
